// file: design/address_comparator.sv
`timescale 1ns/1ps
module address_comparator
    import address_trap_pkg::*;
(
    // Operands
    input wire match_addr_t target,
    input wire match_addr_t probe,
    // Result
    output logic equal
);
    assign equal = (target == probe);
endmodule

// file: design/address_trap_halt.sv
`timescale 1ns/1ps
`include "address_trap_map.svh"
// Behaviour
// - Holds a 21-bit match register, loadable by instruction or from panel.
// - Load-match instruction copies word bits 17-0 into match bits 17-0.
// - Load-match ignores word bits 20-18 and copies bits 23-21 into match bits 20-18.
// - An 18-bit equality comparator checks reference addresses and drives trap logic.
// - With halt switch on, match against program address halts the machine.
// - With halt switch off, bit 23 zero arms the trap, one disarms it.
// - Armed trap with matching reference raises executive trap interrupt level 7.
// - Bit 22 one traps only on writes; zero traps on any access.
// - Bit 21 one matches only in user mode; zero only in monitor mode.
// - Cycle-stealing channel addresses never trigger the trap.
// - Trap stays armed and fires on every qualifying reference.
module address_trap_halt
    import address_trap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register loads
    input wire logic load_match_instruction,
    input wire logic [23:0] load_word,
    input wire logic panel_load,
    input wire logic [23:0] panel_word,
    // Memory reference path
    input wire logic ref_valid,
    input wire logic [17:0] ref_addr,
    input wire logic ref_write,
    input wire logic ref_cycle_steal,
    input wire logic user_mode,
    // Program address path
    input wire logic prog_valid,
    input wire logic [17:0] prog_addr,
    // Panel
    input wire logic halt_on_match_switch,
    // Results
    output logic [20:0] match_value,
    output logic trap_request,
    output logic [2:0] trap_level,
    output logic halt_request
);
    match_addr_t addr_q, addr_d;
    match_ctl_t ctl_q, ctl_d;
    load_src_e src;
    logic ref_eq, prog_eq, mode_ok, access_ok;
    logic trap_d, trap_q, halt_d, halt_q;

    // Program load takes precedence over a simultaneous panel load
    always_comb begin
        if (load_match_instruction) begin
            src = SRC_PROGRAM;
        end else if (panel_load) begin
            src = SRC_PANEL;
        end else begin
            src = SRC_NONE;
        end
    end

    always_comb begin
        addr_d = addr_q;
        ctl_d = ctl_q;
        case (src)
            SRC_PROGRAM: begin
                addr_d = load_word[`MATCH_ADDR_MSB:0];
                ctl_d = load_word[23:21];
            end
            SRC_PANEL: begin
                addr_d = panel_word[`MATCH_ADDR_MSB:0];
                ctl_d = panel_word[23:21];
            end
            default: begin
                addr_d = addr_q;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= `MATCH_RESET_ADDR;
            ctl_q <= `MATCH_RESET_CTL;
        end else begin
            addr_q <= addr_d;
            ctl_q <= ctl_d;
        end
    end

    address_comparator u_ref_cmp (
        .target(addr_q),
        .probe(ref_addr),
        .equal(ref_eq)
    );

    address_comparator u_prog_cmp (
        .target(addr_q),
        .probe(prog_addr),
        .equal(prog_eq)
    );

    always_comb begin
        mode_ok = (user_mode == ctl_q[0]);
        access_ok = ref_write | ~ctl_q[1];
        // Re-fires every qualifying reference; no self-disarm
        trap_d = ~halt_on_match_switch & ~ctl_q[2]
            & ref_valid & ~ref_cycle_steal
            & ref_eq & access_ok & mode_ok;
        halt_d = halt_on_match_switch & prog_valid & prog_eq & mode_ok;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trap_q <= 1'h0;
            halt_q <= 1'h0;
        end else begin
            trap_q <= trap_d;
            halt_q <= halt_d;
        end
    end

    assign match_value = {ctl_q, addr_q};
    assign trap_request = trap_q;
    assign trap_level = `TRAP_LEVEL;
    assign halt_request = halt_q;

    // Register loads
    a_load_copies_word: assert property (@(posedge clk) disable iff (rst)
        load_match_instruction |=>
        match_value == {$past(load_word[23:21]), $past(load_word[17:0])})
        else $error("match load wrong");

    a_load_skips_mid: assert property (@(posedge clk) disable iff (rst)
        load_match_instruction |=>
        match_value[20:18] == $past(load_word[23:21]))
        else $error("control bits misplaced");

    a_program_wins: assert property (@(posedge clk) disable iff (rst)
        (load_match_instruction && panel_load) |=>
        match_value[17:0] == $past(load_word[17:0]))
        else $error("panel load overrode program load");

    a_panel_load: assert property (@(posedge clk) disable iff (rst)
        (panel_load && !load_match_instruction) |=>
        match_value == {$past(panel_word[23:21]), $past(panel_word[17:0])})
        else $error("panel load wrong");

    a_hold_value: assert property (@(posedge clk) disable iff (rst)
        (!load_match_instruction && !panel_load) |=>
        $stable(match_value))
        else $error("match register changed without a load");

    // Reset state
    a_reset_disarms: assert property (@(posedge clk)
        $fell(rst) |->
        ctl_q[2] == 1'h1)
        else $error("reset not disarmed");

    a_reset_quiet: assert property (@(posedge clk)
        $fell(rst) |->
        !trap_request && !halt_request)
        else $error("request pending after reset");

    // Trap path
    a_trap_on_match: assert property (@(posedge clk) disable iff (rst)
        (ref_valid && !ref_cycle_steal && ref_addr == addr_q && !ctl_q[2]
        && !halt_on_match_switch && (ref_write || !ctl_q[1])
        && user_mode == ctl_q[0]) |=>
        trap_request)
        else $error("missed trap");

    a_no_ref_no_trap: assert property (@(posedge clk) disable iff (rst)
        !ref_valid |=>
        !trap_request)
        else $error("trap without a reference");

    a_addr_differs: assert property (@(posedge clk) disable iff (rst)
        (ref_addr != addr_q) |=>
        !trap_request)
        else $error("trap on a different address");

    a_no_trap_disarmed: assert property (@(posedge clk) disable iff (rst)
        ctl_q[2] |=>
        !trap_request)
        else $error("trap while disarmed");

    a_switch_blocks_trap: assert property (@(posedge clk) disable iff (rst)
        halt_on_match_switch |=>
        !trap_request)
        else $error("trap while halt switch on");

    a_steal_ignored: assert property (@(posedge clk) disable iff (rst)
        (ref_cycle_steal && !prog_valid) |=>
        !trap_request && !halt_request)
        else $error("cycle steal trapped");

    a_write_only: assert property (@(posedge clk) disable iff (rst)
        (ctl_q[1] && !ref_write) |=>
        !trap_request)
        else $error("read trapped");

    a_any_access: assert property (@(posedge clk) disable iff (rst)
        (ref_valid && !ref_write && !ref_cycle_steal && ref_addr == addr_q
        && !ctl_q[2] && !ctl_q[1] && !halt_on_match_switch
        && user_mode == ctl_q[0]) |=>
        trap_request)
        else $error("read missed");

    a_mode_gate: assert property (@(posedge clk) disable iff (rst)
        (user_mode != ctl_q[0]) |=>
        !trap_request && !halt_request)
        else $error("wrong mode matched");

    a_refire: assert property (@(posedge clk) disable iff (rst)
        (trap_request && ref_valid && !ref_cycle_steal && ref_addr == addr_q
        && !ctl_q[2] && !halt_on_match_switch && (ref_write || !ctl_q[1])
        && user_mode == ctl_q[0]) |=>
        trap_request)
        else $error("trap self-disarmed");

    a_reload_disarms: assert property (@(posedge clk) disable iff (rst)
        (load_match_instruction && load_word[23]) |->
        ##2 !trap_request)
        else $error("trap after disarming reload");

    // Halt path
    a_halt_on_match: assert property (@(posedge clk) disable iff (rst)
        (halt_on_match_switch && prog_valid && prog_addr == addr_q
        && user_mode == ctl_q[0]) |=>
        halt_request && !trap_request)
        else $error("halt missed");

    a_halt_needs_switch: assert property (@(posedge clk) disable iff (rst)
        !halt_on_match_switch |=>
        !halt_request)
        else $error("halt with switch off");

    a_halt_needs_match: assert property (@(posedge clk) disable iff (rst)
        (!prog_valid || prog_addr != addr_q) |=>
        !halt_request)
        else $error("halt without a match");
endmodule

// file: design/address_trap_map.svh
`ifndef ADDRESS_TRAP_MAP_SVH
`define ADDRESS_TRAP_MAP_SVH

`define MATCH_ADDR_MSB 17
`define MATCH_CTL_ARMOFF 23
`define MATCH_CTL_WRONLY 22
`define MATCH_CTL_USER 21
`define MATCH_RESET_ADDR 18'h00000
`define MATCH_RESET_CTL 3'h4
`define TRAP_LEVEL 3'h7

`endif

// file: design/address_trap_pkg.sv
package address_trap_pkg;
    typedef logic [17:0] match_addr_t;
    typedef logic [2:0] match_ctl_t;
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_PROGRAM,
        SRC_PANEL
    } load_src_e;
endpackage

// file: sim/cpu_ref_model.sv
`timescale 1ns/1ps
module cpu_ref_model (
    // Clock
    input wire logic clk,
    // Reference and program address path
    output logic ref_valid,
    output logic [17:0] ref_addr,
    output logic ref_write,
    output logic ref_cycle_steal,
    output logic user_mode,
    output logic prog_valid,
    output logic [17:0] prog_addr
);
    initial begin
        {ref_valid, ref_write, ref_cycle_steal, user_mode, prog_valid} = 5'h00;
        ref_addr = 18'h3FFFF;
        prog_addr = 18'h3FFFF;
    end
    // n cycles on either path; idle lines show the inverse so a stale address never matches
    task automatic cyc(input logic p, input logic [17:0] a, input logic w, c, u, input int n);
        @(posedge clk) #1;
        ref_valid = !p;
        prog_valid = p;
        ref_addr = a;
        prog_addr = a;
        ref_write = w;
        ref_cycle_steal = c;
        user_mode = u;
        repeat (n) @(posedge clk);
        #1;
        ref_valid = 0;
        prog_valid = 0;
        ref_addr = ~a;
        prog_addr = ~a;
    endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
    $display("BAD %s exp %h got %h", n, e, s); mismatches++; end end
module testbench;
    logic clk = 0, rst = 1, lmi = 0, pl = 0, sw = 0, rv, rw, cs, um, pv, tr, hr, p, w, c, u;
    logic [23:0] lw = 0, pw = 0, shadow = 24'h800000;
    logic [17:0] ra, pa, a;
    logic [20:0] mv;
    logic [2:0] tl;
    int mismatches = 0, num_checks = 0, cyc = 0, n = 1;
    cpu_ref_model i_cpu_ref_model (.clk(clk), .ref_valid(rv), .ref_addr(ra), .ref_write(rw),
        .ref_cycle_steal(cs), .user_mode(um), .prog_valid(pv), .prog_addr(pa));
    address_trap_halt i_address_trap_halt (.clk(clk), .rst(rst), .load_match_instruction(lmi),
        .load_word(lw), .panel_load(pl), .panel_word(pw), .ref_valid(rv), .ref_addr(ra),
        .ref_write(rw), .ref_cycle_steal(cs), .user_mode(um), .prog_valid(pv),
        .prog_addr(pa), .halt_on_match_switch(sw), .match_value(mv), .trap_request(tr),
        .trap_level(tl), .halt_request(hr));
    initial forever #20 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Expected requests, straight from the control bit meanings
    function automatic logic exp_trap(input logic [23:0] t, input logic [17:0] x,
        input logic pp, ss, ww, cc, uu);
        return !pp && !ss && !cc && x == t[17:0] && !t[23] && (ww || !t[22]) && uu == t[21];
    endfunction
    function automatic logic exp_halt(input logic [23:0] t, input logic [17:0] x,
        input logic pp, ss, uu);
        return pp && ss && x == t[17:0] && uu == t[21];
    endfunction
    // Panel always strobes; with both strobes the panel carries a decoy word
    task automatic ld(input logic [23:0] x, input logic s);
        @(posedge clk) #1;
        lmi = s;
        pl = 1;
        lw = s ? x : ~x;
        pw = s ? ~x : x;
        @(posedge clk) #1;
        lmi = 0;
        pl = 0;
        shadow = x;
        `CHK("match_value", {x[23:21], x[17:0]}, mv)
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        void'($urandom(50590));
        repeat (10) @(posedge clk);
        #1 rst = 0;
        `CHK("reset_value", 21'h100000, mv)
        `CHK("trap_level", 3'h7, tl)
        for (int i = 0; i < 600; i++) begin
            if (i % 4 == 3) ld(24'($urandom), 1'($urandom));
            p = 1'($urandom);
            w = 1'($urandom);
            c = ($urandom % 4) == 0;
            u = 1'($urandom);
            n = 1 + ($urandom % 3);
            sw = p ^ (($urandom % 8) == 0);
            a = ($urandom % 2) ? shadow[17:0] : 18'($urandom);
            i_cpu_ref_model.cyc(p, a, w, c, u, n);
            `CHK("trap", exp_trap(shadow, a, p, sw, w, c, u), tr)
            `CHK("halt", exp_halt(shadow, a, p, sw, u), hr)
        end
        // Corner: bits 20-18 set in the source word, then a burst of user reads
        sw = 0;
        ld(24'h3C1234, 1'h1);
        i_cpu_ref_model.cyc(1'h0, 18'h01234, 1'h0, 1'h0, 1'h1, 3);
        `CHK("trap_burst", 1'h1, tr)
        // Corner: reset in mid-run puts the register back to disarmed
        @(posedge clk) #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        shadow = 24'h800000;
        `CHK("reset_again", 21'h100000, mv)
        `CHK("trap_after_reset", 1'h0, tr)
        i_cpu_ref_model.cyc(1'h0, 18'h00000, 1'h0, 1'h0, 1'h0, 1);
        `CHK("disarmed_trap", 1'h0, tr)
        give_verdict;
    end
endmodule
